// [fsc_params.svh]
/*
  Constants of the fault status and configuration register bank: register
  offsets, field positions, reset values and timing figures.
  Assumes it is included by bare name; it holds definitions only.
*/
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// ==========================================================================
// register offsets
`define OFS_RAIL_UV_STATUS   8'h05
`define OFS_FAULT_STATUS_TWO 8'h06
`define OFS_GENERAL_SETTINGS 8'h07

// ==========================================================================
// rail undervoltage status bit positions
`define BIT_POS_SUPPLY_LOW   6
`define BIT_NEG_SUPPLY_LOW   4
`define BIT_GATE_HIGH_LOW    2
`define BIT_GATE_NEG_LOW     0

// ==========================================================================
// second fault status bit positions
`define BIT_V18_RANGE        7
`define BIT_PARITY_ERR       6
`define BIT_INPUT_UVLO       5
`define BIT_BOOST_UV         4
`define BIT_THERM_SHDN       3
`define BIT_NVM_FAIL         2
`define BIT_VCOM_FAULT       1
`define BIT_THERM_WARN       0

// ==========================================================================
// general settings fields, settings and status reset values
`define BIT_INT_SENSOR       7
`define BIT_REFRESH          6
`define BIT_SPREAD_EN        5
`define BIT_FSW_SEL          4
`define RETRY_HI             3
`define RETRY_LO             2
`define TFAULT_HI            1
`define TFAULT_LO            0
`define SETTINGS_RESET       8'h04
`define STATUS_RESET         8'h00

// ==========================================================================
// timing figures
`define CLK_HZ               40000000
`define RETRY_SHORT_MS       950
`define RETRY_LONG_MS        1900
`define TFAULT0_MS           15
`define TFAULT1_MS           30
`define TFAULT2_MS           60
`define TFAULT3_MS           90
`define RETRY_LIMIT          2'd3

`endif

// [fsc_pkg.sv]
/*
  Types of the fault status and configuration register bank.
  Assumes nothing of its surroundings.
*/
package fsc_pkg;

  // ==========================================================================
  // output enable supervisor states
  typedef enum logic [1:0] {
    st_run     = 2'b00,
    st_uvlo    = 2'b01,
    st_wait    = 2'b10,
    st_latched = 2'b11
  } supervisor_state_t;

endpackage

// [signal_sync.sv]
/*
  Three-stage synchroniser for a group of level inputs from outside the
  clock domain; a change is taken once the second and third stages agree.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module signal_sync #(
  parameter int W = 11
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // ==========================================================================
  // shift chain; stage1 is read only by stage2
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ==========================================================================
  // per bit, take the new level once two stages agree
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sync <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          o_sync[i] <= stage3[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// [fault_status_config_regs.sv]
/*
  Fault status and configuration register bank of a display power supply:
  read-clear fault flags, general settings, fault output, VCOM current
  limit timing and output enable supervision with retry.
  Assumes a register port driven by the serial target front end on i_clk,
  and comparator levels from the analog side on asynchronous pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsc_params.svh"

// Functional notes
// - A negative supply, gate high or gate negative undervoltage sets bit 4, 2 or 0 of the rail status register.
// - A parity error reported by the serial interface sets bit 6 of the second status register.
// - An input undervoltage lockout sets bit 5 of the second status register.
// - Input lockout turns every output off, and on recovery the outputs restart in sequence.
// - A 0.25V VCOM deviation, or VCOM current limit lasting the fault delay, sets bit 1.
// - Settings bit 7 at 1 selects the internal temperature sensor.
// - The retry field gives no retry, 0.95s with 3 retries, 1.9s with 3 retries, or 1.9s unlimited.
// - The fault delay field gives 15ms, 30ms, 60ms or 90ms for codes 0 to 3.
// - A fault whose mask bit is 1 does not pull the fault output low.
module fault_status_config_regs
  import fsc_pkg::*;
#(
  parameter int unsigned RETRY_SHORT_CYC = `RETRY_SHORT_MS * (`CLK_HZ / 1000),
  parameter int unsigned RETRY_LONG_CYC  = `RETRY_LONG_MS * (`CLK_HZ / 1000),
  parameter int unsigned TFAULT0_CYC     = `TFAULT0_MS * (`CLK_HZ / 1000),
  parameter int unsigned TFAULT1_CYC     = `TFAULT1_MS * (`CLK_HZ / 1000),
  parameter int unsigned TFAULT2_CYC     = `TFAULT2_MS * (`CLK_HZ / 1000),
  parameter int unsigned TFAULT3_CYC     = `TFAULT3_MS * (`CLK_HZ / 1000)
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // register port from the serial target
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // same-clock event strobes
  input  wire logic       i_parity_err,
  input  wire logic       i_nvm_fail,
  // analog comparator levels, asynchronous
  input  wire logic       i_pos_supply_low,
  input  wire logic       i_neg_supply_low,
  input  wire logic       i_gate_high_low,
  input  wire logic       i_gate_neg_low,
  input  wire logic       i_v18_out_of_range,
  input  wire logic       i_input_uvlo,
  input  wire logic       i_boost_low,
  input  wire logic       i_therm_shdn,
  input  wire logic       i_therm_warn,
  input  wire logic       i_vcom_deviation,
  input  wire logic       i_vcom_ilim,
  // masks from the mask registers
  input  wire logic [7:0] i_rail_mask,
  input  wire logic [7:0] i_fault_status_two_mask,
  // fault pin and power control
  output logic            o_fault_output_n,
  output logic            o_outputs_en,
  output logic            o_seq_start,
  // settings to the analog side
  output logic            o_use_int_sensor,
  output logic            o_refresh_en,
  output logic            o_spread_en,
  output logic            o_fsw_low
);

  // ==========================================================================
  // declarations
  localparam int NS = 11;
  logic [NS-1:0]     sync_lvl;
  logic [7:0]        rail_uv_status;
  logic [7:0]        fault_status_two;
  logic [7:0]        general_settings;
  logic [7:0]        rail_events;
  logic [7:0]        fault_status_two_events;
  logic              rd_rail;
  logic              rd_fault_status_two;
  logic [25:0]       ilim_cnt;
  logic              ilim_expired;
  logic [26:0]       retry_cnt;     // the long retry wait needs 27 bits at 40 MHz
  logic [1:0]        retries_done;
  logic              shutdown_fault;
  supervisor_state_t state;
  supervisor_state_t next_state;

  // fault delay in cycles for a field code
  function automatic logic [25:0] tfault_cycles(input logic [1:0] code);
    unique case (code)
      2'd0: tfault_cycles = TFAULT0_CYC[25:0];
      2'd1: tfault_cycles = TFAULT1_CYC[25:0];
      2'd2: tfault_cycles = TFAULT2_CYC[25:0];
      2'd3: tfault_cycles = TFAULT3_CYC[25:0];
    endcase
  endfunction

  // retry wait in cycles for a nonzero retry code
  function automatic logic [26:0] retry_cycles(input logic [1:0] code);
    retry_cycles = (code == 2'd1) ? RETRY_SHORT_CYC[26:0] : RETRY_LONG_CYC[26:0];
  endfunction

  // ==========================================================================
  // synchronise analog levels
  signal_sync #(
    .W (NS)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  ({i_pos_supply_low, i_neg_supply_low, i_gate_high_low, i_gate_neg_low,
                i_v18_out_of_range, i_input_uvlo, i_boost_low, i_therm_shdn,
                i_therm_warn, i_vcom_deviation, i_vcom_ilim}),
    .o_sync   (sync_lvl)
  );

  // named views of the synchronised levels
  logic pos_low, neg_low, ghi_low, gneg_low, v18_oor, in_uvlo;
  logic boost_low, th_shdn, th_warn, vcom_dev, vcom_ilim;
  assign {pos_low, neg_low, ghi_low, gneg_low, v18_oor, in_uvlo,
          boost_low, th_shdn, th_warn, vcom_dev, vcom_ilim} = sync_lvl;

  // ==========================================================================
  // register port decode
  assign rd_rail   = i_reg_rd && (i_reg_addr == `OFS_RAIL_UV_STATUS);
  assign rd_fault_status_two = i_reg_rd && (i_reg_addr == `OFS_FAULT_STATUS_TWO);

  // registered read data; unmapped offsets read as zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `OFS_RAIL_UV_STATUS:   o_reg_rdata <= rail_uv_status;
        `OFS_FAULT_STATUS_TWO: o_reg_rdata <= fault_status_two;
        `OFS_GENERAL_SETTINGS: o_reg_rdata <= general_settings;
        default:               o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // general settings register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      general_settings <= `SETTINGS_RESET;
    end else if (i_reg_wr && (i_reg_addr == `OFS_GENERAL_SETTINGS)) begin
      general_settings <= i_reg_wdata;
    end
  end

  // settings fields to the analog side
  assign o_use_int_sensor = general_settings[`BIT_INT_SENSOR];
  assign o_refresh_en     = general_settings[`BIT_REFRESH];
  assign o_spread_en      = general_settings[`BIT_SPREAD_EN];
  assign o_fsw_low        = general_settings[`BIT_FSW_SEL];

  // ==========================================================================
  // vcom current limit must persist for the fault delay
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ilim_cnt <= 26'h0;
    end else if (!vcom_ilim) begin
      ilim_cnt <= 26'h0;
    end else if (!ilim_expired) begin
      ilim_cnt <= ilim_cnt + 26'h1;
    end
  end
  assign ilim_expired = vcom_ilim &&
    (ilim_cnt >= tfault_cycles(general_settings[`TFAULT_HI:`TFAULT_LO]) - 26'h1);

  // ==========================================================================
  // fault events feeding the sticky flags
  always_comb begin
    rail_events                        = 8'h00;
    rail_events[`BIT_POS_SUPPLY_LOW]   = pos_low;
    rail_events[`BIT_NEG_SUPPLY_LOW]   = neg_low;
    rail_events[`BIT_GATE_HIGH_LOW]    = ghi_low;
    rail_events[`BIT_GATE_NEG_LOW]     = gneg_low;
    fault_status_two_events                      = 8'h00;
    fault_status_two_events[`BIT_V18_RANGE]      = v18_oor;
    fault_status_two_events[`BIT_PARITY_ERR]     = i_parity_err;
    fault_status_two_events[`BIT_INPUT_UVLO]     = in_uvlo;
    fault_status_two_events[`BIT_BOOST_UV]       = boost_low;
    fault_status_two_events[`BIT_THERM_SHDN]     = th_shdn;
    fault_status_two_events[`BIT_NVM_FAIL]       = i_nvm_fail;
    fault_status_two_events[`BIT_VCOM_FAULT]     = vcom_dev || ilim_expired;
    fault_status_two_events[`BIT_THERM_WARN]     = th_warn;
  end

  // sticky flags; a read clears all flags of the register read, a same-cycle event wins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rail_uv_status   <= `STATUS_RESET;
      fault_status_two <= `STATUS_RESET;
    end else begin
      rail_uv_status   <= (rd_rail ? 8'h00 : rail_uv_status) | rail_events;
      fault_status_two <= (rd_fault_status_two ? 8'h00 : fault_status_two) | fault_status_two_events;
    end
  end

  // ==========================================================================
  // fault output, low while any unmasked flag is set
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fault_output_n <= 1'b1;
    end else begin
      o_fault_output_n <= ~(|(rail_uv_status & ~i_rail_mask) |
                            |(fault_status_two & ~i_fault_status_two_mask));
    end
  end

  // ==========================================================================
  // output supervisor: lockout, shutdown faults and retry
  assign shutdown_fault = pos_low | neg_low | ghi_low | gneg_low | boost_low | th_shdn;

  always_comb begin
    next_state = state;
    unique case (state)
      st_run: begin
        if (in_uvlo) begin
          next_state = st_uvlo;
        end else if (shutdown_fault) begin
          if (general_settings[`RETRY_HI:`RETRY_LO] == 2'd0) begin
            next_state = st_latched;
          end else if (general_settings[`RETRY_HI:`RETRY_LO] != 2'd3 &&
                       retries_done == `RETRY_LIMIT) begin
            next_state = st_latched;
          end else begin
            next_state = st_wait;
          end
        end
      end
      st_uvlo: begin
        if (!in_uvlo) begin
          next_state = st_run;
        end
      end
      st_wait: begin
        if (in_uvlo) begin
          next_state = st_uvlo;
        end else if (retry_cnt == 27'h0) begin
          next_state = st_run;
        end
      end
      st_latched: begin
        if (in_uvlo) begin
          next_state = st_uvlo;
        end
      end
    endcase
  end

  // state register; start in lockout so the first power-up runs the sequence
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= st_uvlo;
    end else begin
      state <= next_state;
    end
  end

  // retry wait timer and retry count
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      retry_cnt    <= 27'h0;
      retries_done <= 2'd0;
    end else begin
      if (state == st_run && next_state == st_wait) begin
        retry_cnt <= retry_cycles(general_settings[`RETRY_HI:`RETRY_LO]) - 27'h1;
      end else if (state == st_wait && retry_cnt != 27'h0) begin
        retry_cnt <= retry_cnt - 27'h1;
      end
      if (state == st_uvlo) begin
        retries_done <= 2'd0;
      end else if (state == st_wait && next_state == st_run && retries_done != 2'd3) begin
        retries_done <= retries_done + 2'd1;
      end
    end
  end

  // outputs on only while running; a start pulse opens each power-up
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_outputs_en <= 1'b0;
      o_seq_start  <= 1'b0;
    end else begin
      o_outputs_en <= (next_state == st_run);
      o_seq_start  <= (next_state == st_run) && (state != st_run);
    end
  end

endmodule

`default_nettype wire

// [fsc_host_model.sv]
/*
  Register host model driving the bank's register port.
  Assumes one clock; read data is taken on the falling edge after the edge that samples the read.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// register host
module fsc_host_model (
  // clock
  input  wire logic       i_clk,
  // register port
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  // idle port at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one transfer; strobes drop to 0, released address and data lines show inverted values
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= ~w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    @(negedge i_clk);
    q = i_rdata;
  endtask
endmodule
`default_nettype wire

// [fault_status_config_regs_props.sv]
/*
  Port checker of the fault register bank.
  Assumes it is bound to every bank instance.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// checker
module fsc_props (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // fault sources and masks
  input wire logic       i_parity_err,
  input wire logic       i_pos_supply_low,
  input wire logic       i_neg_supply_low,
  input wire logic       i_gate_high_low,
  input wire logic       i_gate_neg_low,
  input wire logic       i_input_uvlo,
  input wire logic       i_boost_low,
  input wire logic       i_therm_shdn,
  input wire logic [7:0] i_rail_mask,
  input wire logic [7:0] i_fault_status_two_mask,
  // pins and settings
  input wire logic       o_fault_output_n,
  input wire logic       o_outputs_en,
  input wire logic       o_use_int_sensor,
  input wire logic       o_refresh_en,
  input wire logic       o_spread_en,
  input wire logic       o_fsw_low
);
  // no shutdown cause present
  wire logic quiet = ~(i_input_uvlo | i_pos_supply_low | i_neg_supply_low | i_gate_high_low
                       | i_gate_neg_low | i_boost_low | i_therm_shdn);
  wire logic [3:0] sets = {o_use_int_sensor, o_refresh_en, o_spread_en, o_fsw_low};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_wr_settings;
    i_reg_wr && i_reg_addr == 8'h07 |=> sets == $past(i_reg_wdata[7:4]);
  endproperty
  a_wr_settings: assert property (p_wr_settings) else $error("settings differ from write");
  property p_hold;
    !i_reg_rd |=> $stable(o_reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_parity;
    i_parity_err && !i_fault_status_two_mask[6] ##1 !i_fault_status_two_mask[6] |-> ##[1:3] !o_fault_output_n;
  endproperty
  a_parity: assert property (p_parity) else $error("parity error left pin high");
  property p_rail;
    ((i_neg_supply_low && !i_rail_mask[4]) || (i_gate_high_low && !i_rail_mask[2])
     || (i_gate_neg_low && !i_rail_mask[0]))[*7] |-> !o_fault_output_n;
  endproperty
  a_rail: assert property (p_rail) else $error("rail fault left pin high");
  property p_uvlo_pin;
    (i_input_uvlo && !i_fault_status_two_mask[5])[*7] |-> !o_fault_output_n;
  endproperty
  a_uvlo_pin: assert property (p_uvlo_pin) else $error("lockout left pin high");
  property p_lockout;
    i_input_uvlo[*6] |-> !o_outputs_en;
  endproperty
  a_lockout: assert property (p_lockout) else $error("outputs on in lockout");
  property p_restart;
    i_input_uvlo[*6] ##1 quiet[*8] |-> o_outputs_en;
  endproperty
  a_restart: assert property (p_restart) else $error("outputs off after lockout");
  property p_mask;
    (i_rail_mask == 8'hff && i_fault_status_two_mask == 8'hff)[*3] |-> o_fault_output_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked fault drove pin");
endmodule
bind fault_status_config_regs fsc_props fsc_props_i (.*);
`default_nettype wire

// [fault_status_config_regs_tb_top.sv]
/*
  Testbench of the fault register bank: host model on the register port,
  bench levels on the comparator pins. Assumes the checker is bound.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// bench top
module fault_status_config_regs_tb_top;
  // clock, reset and bank pins
  logic       i_clk         = 1'b0;
  logic       i_arst_n      = 1'b0;
  logic [7:0] lv            = 8'h00;
  logic [7:0] i_rail_mask   = 8'h00;
  logic [7:0] i_fault_status_two_mask = 8'h00;
  logic [4:0] ex            = 5'h00;
  wire logic i_nvm_fail, i_pos_supply_low, i_v18_out_of_range, i_therm_shdn, i_therm_warn;
  wire logic i_reg_wr, i_reg_rd, i_parity_err, i_vcom_ilim, i_vcom_deviation, i_boost_low;
  wire logic i_input_uvlo, i_gate_neg_low, i_gate_high_low, i_neg_supply_low;
  wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  wire logic o_fault_output_n, o_outputs_en, o_seq_start;
  wire logic o_use_int_sensor, o_refresh_en, o_spread_en, o_fsw_low;
  wire logic [3:0] sets = {o_use_int_sensor, o_refresh_en, o_spread_en, o_fsw_low};
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed;
  logic [7:0] q, v;
  // bench levels: par, ilim, vdev, boost, uvlo, gate neg, gate high, neg supply
  assign {i_parity_err, i_vcom_ilim, i_vcom_deviation, i_boost_low,
          i_input_uvlo, i_gate_neg_low, i_gate_high_low, i_neg_supply_low} = lv;
  // more bench levels: pos supply, 1.8v range, thermal shutdown, thermal warn, nvm strobe
  assign {i_pos_supply_low, i_v18_out_of_range, i_therm_shdn, i_therm_warn, i_nvm_fail} = ex;
  always #12.5 i_clk = ~i_clk;
  fault_status_config_regs #(.RETRY_SHORT_CYC(20), .RETRY_LONG_CYC(40), .TFAULT0_CYC(8),
    .TFAULT1_CYC(16), .TFAULT2_CYC(32), .TFAULT3_CYC(48)) fault_status_config_regs_i (.*);
  fsc_host_model fsc_host_model_i (.i_clk(i_clk), .i_rdata(o_reg_rdata), .o_wr(i_reg_wr),
    .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
  // ==========================================================================
  // helpers
  function automatic int f_wait(int c);
    return (c == 1) ? 20 : 40;
  endfunction
  function automatic logic f_on(int c, int k);
    return (c == 3) || (c != 0 && k < 3);
  endfunction
  function automatic int f_tf(int c);
    return (c == 3) ? 48 : (8 << c);
  endfunction
  // second status flag expected for each extra level
  function automatic logic [7:0] f_fl(int e);
    return (e == 0) ? 8'h04 : (e == 1) ? 8'h01 : (e == 2) ? 8'h08 : (e == 3) ? 8'h80 : 8'h00;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    fsc_host_model_i.xfer(1'b0, a, 8'h00, q);
    chk("rdata", e, q);
  endtask
  task automatic wr(input logic [7:0] a, d);
    fsc_host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic hold(input int b, input int n);
    @(posedge i_clk);
    lv[b] <= 1'b1;
    wt(n);
    lv[b] <= 1'b0;
  endtask
  task automatic pin(input string n, input logic e, g);
    chk(n, {7'h0, e}, {7'h0, g});
  endtask
  task automatic recover;
    hold(3, 8);
    @(negedge i_clk);
    pin("outputs_en", 1'b0, o_outputs_en);
    wt(4);
    @(negedge i_clk);
    pin("seq_start", 1'b0, o_seq_start);
    wt(1);
    @(negedge i_clk);
    pin("seq_start", 1'b1, o_seq_start);
    wt(5);
    @(negedge i_clk);
    pin("outputs_en", 1'b1, o_outputs_en);
  endtask
  task automatic conclude;
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    seed = $urandom(32'hf186);
    wt(8);
    i_arst_n <= 1'b1;
    rd(8'h07, 8'h04);
    rd(8'h06, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h3c, 8'h00);
    wr(8'h06, 8'hff);
    rd(8'h06, 8'h00);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hf0 : (i == 1) ? 8'h0f : 8'($urandom);
      wr(8'h07, v);
      rd(8'h07, v);
      chk("settings", {4'h0, v[7:4]}, {4'h0, sets});
    end
    hold(7, 1);
    wt(3);
    @(negedge i_clk);
    pin("fault_n", 1'b0, o_fault_output_n);
    rd(8'h06, 8'h40);
    rd(8'h06, 8'h00);
    i_fault_status_two_mask <= 8'h40;
    hold(7, 1);
    wt(3);
    @(negedge i_clk);
    pin("fault_n", 1'b1, o_fault_output_n);
    @(posedge i_clk);
    i_rail_mask <= 8'hff;
    i_fault_status_two_mask <= 8'hff;
    wt(4);
    i_rail_mask <= 8'h00;
    i_fault_status_two_mask <= 8'h00;
    wt(2);
    @(negedge i_clk);
    pin("fault_n", 1'b0, o_fault_output_n);
    rd(8'h06, 8'h40);
    for (int b = 0; b < 3; b++) begin
      hold(b, 8);
      wt(6);
      rd(8'h05, 8'h10 >> (2 * b));
      rd(8'h05, 8'h00);
    end
    for (int e = 0; e < 5; e++) begin
      @(posedge i_clk);
      ex[e] <= 1'b1;
      wt(8);
      ex[e] <= 1'b0;
      wt(6);
      rd(8'h05, (e == 4) ? 8'h40 : 8'h00);
      rd(8'h06, f_fl(e));
    end
    recover();
    rd(8'h06, 8'h20);
    rd(8'h06, 8'h00);
    hold(5, 6);
    wt(6);
    rd(8'h06, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(8'h07, {6'h00, 2'(c)});
      hold(6, f_tf(c) - 1);
      wt(6);
      rd(8'h06, 8'h00);
      hold(6, f_tf(c));
      wt(6);
      rd(8'h06, 8'h02);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h07, {4'h0, 2'(c), 2'b00});
      for (int k = 0; k < 4; k++) begin
        hold(4, 6);
        wt(f_wait(c) - 6);
        @(negedge i_clk);
        pin("outputs_en", 1'b0, o_outputs_en);
        wt(12);
        @(negedge i_clk);
        pin("outputs_en", f_on(c, k), o_outputs_en);
      end
      recover();
    end
    conclude();
  end
endmodule
`default_nettype wire
